// File: rtl/txg_core.sv
/*
  Transmit path control: attenuation register, gain port, serial
  register port, sample FIFO and 2x/4x half-band interpolator.
  Assumes all inputs synchronous to clk_i, the serial clock slower
  than a quarter of clk_i, and a converter that pulls dac_ready_i.
*/
`include "txg_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module txg_fifo #(
  parameter int W = 12,
  parameter int D = 32
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [0:D-1];
  logic [AW:0]  wp_reg, wp_next, rp_reg, rp_next;
  logic         push, pop;

  assign in_ready_o  = (wp_reg - rp_reg) != (AW+1)'(D);
  assign out_valid_o = wp_reg != rp_reg;
  assign out_data_o  = mem[rp_reg[AW-1:0]];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb
  begin
    wp_next = push ? wp_reg + 1'b1 : wp_reg;
    rp_next = pop ? rp_reg + 1'b1 : rp_reg;
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
    end
    else
    begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
    end
    if (push)
      mem[wp_reg[AW-1:0]] <= in_data_i;
  end
endmodule

module txg_halfband #(
  parameter int              W    = 12,
  parameter int              TAPS = 43,
  parameter logic [16*((TAPS+1)/4)-1:0] COEF = '0
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o
);
  // odd phase of a half-band: (TAPS+1)/2 nonzero taps, symmetric
  localparam int L = (TAPS+1)/2;
  logic [W-1:0] hist_reg [0:L-1];
  logic [W-1:0] hist_next [0:L-1];
  logic [W-1:0] out_reg, out_next;
  logic         vld_reg, vld_next, odd_reg, odd_next, take;
  logic signed [W+20:0] acc;
  // every operand widened first so the tap product is never cut to 16 bits

  assign in_ready_o  = !vld_reg || (out_ready_i && !odd_reg);
  assign out_valid_o = vld_reg;
  assign out_data_o  = out_reg;
  assign take        = in_valid_i & in_ready_o;

  always_comb
  begin
    acc = '0;
    for (int k = 0; k < L/2; k++)
      acc = acc + (W+21)'(signed'(COEF[16*k +: 16]))
            * ((W+21)'(signed'(hist_reg[k])) + (W+21)'(signed'(hist_reg[L-1-k])));
    hist_next = hist_reg;
    out_next  = out_reg;
    vld_next  = vld_reg;
    odd_next  = odd_reg;
    if (vld_reg && out_ready_i)
    begin
      out_next = acc[W+14:15];
      vld_next = odd_reg;
      odd_next = 1'b0;
    end
    if (take)
    begin
      for (int k = L-1; k > 0; k--)
        hist_next[k] = hist_reg[k-1];
      hist_next[0] = in_data_i;
      out_next     = hist_reg[L/2-1];
      vld_next     = 1'b1;
      odd_next     = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      for (int k = 0; k < L; k++)
        hist_reg[k] <= '0;
      out_reg <= '0;
      vld_reg <= 1'b0;
      odd_reg <= 1'b0;
    end
    else
    begin
      hist_reg <= hist_next;
      out_reg  <= out_next;
      vld_reg  <= vld_next;
      odd_reg  <= odd_next;
    end
  end
endmodule

module txg_core #(
  parameter int         W        = 12,
  parameter int         DEPTH    = 32,
  parameter logic [2:0] DEF_PRIM = 3'h4,
  parameter logic [2:0] DEF_S1   = 3'h4,
  parameter logic [2:0] DEF_S2   = 3'h4,
  parameter logic [2:0] DEF_S3   = 3'h3
) (
  // clock and reset
  input  wire logic            clk_i,
  input  wire logic            resetn_i,
  // serial register port
  input  wire logic            spi_sclk_i,
  input  wire logic            spi_csn_i,
  input  wire logic            spi_sdi_i,
  output logic                 spi_sdo_o,
  output logic                 spi_sdo_oe_o,
  // parallel gain port
  input  wire logic [5:0]      gain_port_i,
  output logic [5:0]           rx_gain_stage_o,
  output logic                 rx_gain_stage_load_o,
  // transmit samples
  input  wire logic            tx_valid_i,
  output logic                 tx_ready_o,
  input  wire logic [W-1:0]    tx_data_i,
  input  wire logic            tx_enable_i,
  // converter side
  output logic                 dac_valid_o,
  input  wire logic            dac_ready_i,
  output logic [W-1:0]         dac_data_o,
  output txg_pkg::txg_gain_t   tx_gain_o,
  output logic                 converter_direct_o,
  output logic                 current_amplifier_en_o,
  output txg_pkg::txg_mirror_t mirror_o,
  output txg_pkg::txg_offset_t offset_current_o,
  // half-duplex power-down
  input  wire logic            hd_pd_en_i,
  input  wire logic [7:0]      pd_delay_i,
  output logic                 tx_converter_pd_o,
  output logic                 current_amplifier_pd_o
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] clamp3(input logic [2:0] v, input logic [2:0] m);
    clamp3 = (v > m) ? m : v;
  endfunction

  // ----------------------------------------------------------------
  // serial register port
  // ----------------------------------------------------------------
  logic [4:0] cnt_reg, cnt_next;
  logic [15:0] sh_reg, sh_next;
  logic [7:0] osh_reg, osh_next, rdata;
  logic       sclk_reg, rd_reg, rd_next, sdo_reg, sdo_next, oe_reg, oe_next;
  logic       wr, rise, fall;
  logic [6:0] waddr, raddr;
  logic [7:0] wdata;
  logic [7:0] atten_reg, sel_reg, interp_reg, route_reg, m1_reg, m2_reg, off_reg;

  assign rise  = spi_sclk_i & !sclk_reg;
  assign fall  = !spi_sclk_i & sclk_reg;
  // after fifteen rises bit 14 holds the read flag, the address sits below it
  assign waddr = sh_reg[13:7];
  // at the eighth rise the last address bit is still on sdi, not yet shifted
  assign raddr = {sh_reg[5:0], spi_sdi_i};
  assign wdata = {sh_reg[6:0], spi_sdi_i};
  assign wr    = !spi_csn_i && rise && !rd_reg && cnt_reg == `TXG_SPI_BITS - 5'h01;

  always_comb
  begin
    rdata = 8'h00;
    if (raddr == `TXG_OFS_ATTEN)
      rdata = {1'b0, atten_reg[6:0]};
    else if (raddr == `TXG_OFS_PORTSEL)
      rdata = sel_reg;
    else if (raddr == `TXG_OFS_INTERP)
      rdata = interp_reg;
    else if (raddr == `TXG_OFS_ROUTE)
      rdata = route_reg;
    else if (raddr == `TXG_OFS_MIRROR1)
      rdata = m1_reg;
    else if (raddr == `TXG_OFS_MIRROR2)
      rdata = m2_reg;
    else if (raddr == `TXG_OFS_OFFSET)
      rdata = off_reg;
  end

  always_comb
  begin
    cnt_next = cnt_reg;
    sh_next  = sh_reg;
    osh_next = osh_reg;
    rd_next  = rd_reg;
    sdo_next = sdo_reg;
    oe_next  = oe_reg;
    if (spi_csn_i)
    begin
      cnt_next = '0;
      oe_next  = 1'b0;
    end
    else if (rise)
    begin
      sh_next  = {sh_reg[14:0], spi_sdi_i};
      cnt_next = cnt_reg + 5'h01;
      if (cnt_reg == 5'h00)
        rd_next = spi_sdi_i;
      if (cnt_reg == 5'h07)
        osh_next = rdata;
    end
    else if (fall && cnt_reg >= 5'h08 && cnt_reg < `TXG_SPI_BITS)
    begin
      sdo_next = osh_reg[7];
      osh_next = {osh_reg[6:0], 1'b0};
      oe_next  = rd_reg;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      cnt_reg  <= '0;
      sh_reg   <= '0;
      osh_reg  <= '0;
      rd_reg   <= 1'b0;
      sdo_reg  <= 1'b0;
      oe_reg   <= 1'b0;
      sclk_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      sh_reg   <= sh_next;
      osh_reg  <= osh_next;
      rd_reg   <= rd_next;
      sdo_reg  <= sdo_next;
      oe_reg   <= oe_next;
      sclk_reg <= spi_sclk_i;
    end
  end

  assign spi_sdo_o    = sdo_reg;
  assign spi_sdo_oe_o = oe_reg;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [7:0] atten_next, sel_next, interp_next, route_next, m1_next, m2_next, off_next;
  logic       wr_atten;

  assign wr_atten = wr && waddr == `TXG_OFS_ATTEN;

  always_comb
  begin
    atten_next  = atten_reg;
    sel_next    = sel_reg;
    interp_next = interp_reg;
    route_next  = route_reg;
    m1_next     = m1_reg;
    m2_next     = m2_reg;
    off_next    = off_reg;
    if (sel_reg[`TXG_BIT_SEL_TX])
      atten_next[5:0] = gain_port_i;
    if (wr_atten)
    begin
      atten_next[`TXG_BIT_SPI_EN] = wdata[`TXG_BIT_SPI_EN];
      if (wdata[`TXG_BIT_SPI_EN])
        atten_next[5:0] = wdata[5:0];
    end
    else if (wr && waddr == `TXG_OFS_PORTSEL)
      sel_next = wdata;
    else if (wr && waddr == `TXG_OFS_INTERP)
    begin
      interp_next[5:0] = wdata[5:0];
      if (wdata[7:6] != txg_pkg::TXG_XX)
        interp_next[7:6] = wdata[7:6];
    end
    else if (wr && waddr == `TXG_OFS_ROUTE)
      route_next = wdata;
    else if (wr && waddr == `TXG_OFS_MIRROR1)
      m1_next = wdata;
    else if (wr && waddr == `TXG_OFS_MIRROR2)
      m2_next = wdata;
    else if (wr && waddr == `TXG_OFS_OFFSET)
      off_next = wdata;
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      atten_reg  <= `TXG_RST_ATTEN;
      sel_reg    <= `TXG_RST_PORTSEL;
      interp_reg <= `TXG_RST_INTERP;
      route_reg  <= `TXG_RST_ROUTE;
      m1_reg     <= `TXG_RST_MIRROR1;
      m2_reg     <= `TXG_RST_MIRROR2;
      off_reg    <= `TXG_RST_OFFSET;
    end
    else
    begin
      atten_reg  <= atten_next;
      sel_reg    <= sel_next;
      interp_reg <= interp_next;
      route_reg  <= route_next;
      m1_reg     <= m1_next;
      m2_reg     <= m2_next;
      off_reg    <= off_next;
    end
  end

  // receive gain register lives elsewhere; the port feeds it while selected
  assign rx_gain_stage_o      = gain_port_i;
  assign rx_gain_stage_load_o = sel_reg[`TXG_BIT_SEL_RX];

  // ----------------------------------------------------------------
  // gain mapping and current mirrors
  // ----------------------------------------------------------------
  logic [5:0] code;

  always_comb
  begin
    code = (atten_reg[5:0] > `TXG_MAX_CODE) ? `TXG_MAX_CODE : atten_reg[5:0];
    if (route_reg[`TXG_BIT_ROUTE])
    begin
      tx_gain_o.conv_steps = atten_reg[3:0];
      tx_gain_o.amp_steps  = 2'h0;
    end
    else if (code >= 2'h2 * `TXG_AMP_STEP)
    begin
      // converter 0..15 half-dB steps, amplifier 6 dB steps on top
      tx_gain_o.amp_steps  = 2'h2;
      tx_gain_o.conv_steps = 4'(code - 2'h2 * `TXG_AMP_STEP);
    end
    else if (code >= `TXG_AMP_STEP)
    begin
      tx_gain_o.amp_steps  = 2'h1;
      tx_gain_o.conv_steps = 4'(code - `TXG_AMP_STEP);
    end
    else
    begin
      tx_gain_o.amp_steps  = 2'h0;
      tx_gain_o.conv_steps = code[3:0];
    end
    if (m1_reg[`TXG_BIT_MIR_EN])
    begin
      mirror_o.primary    = clamp3(m1_reg[2:0], 3'h4);
      mirror_o.sec_first  = clamp3(m1_reg[6:4], 3'h4);
      mirror_o.sec_second = clamp3(m2_reg[6:4], 3'h6);
      mirror_o.sec_third  = clamp3(m2_reg[2:0], 3'h5);
    end
    else
    begin
      mirror_o.primary    = DEF_PRIM;
      mirror_o.sec_first  = DEF_S1;
      mirror_o.sec_second = DEF_S2;
      mirror_o.sec_third  = DEF_S3;
    end
  end

  assign converter_direct_o     = route_reg[`TXG_BIT_ROUTE];
  assign current_amplifier_en_o = !route_reg[`TXG_BIT_ROUTE] && !current_amplifier_pd_o;
  assign offset_current_o       = {off_reg[6:4], off_reg[2:0]};

  // ----------------------------------------------------------------
  // sample path: FIFO, interpolator, bypass
  // ----------------------------------------------------------------
  logic         f_vld, f_rdy, s1_vld, s1_rdy, s1_ordy, s2_vld, s2_rdy;
  logic [W-1:0] f_dat, s1_dat, s2_dat;
  txg_pkg::txg_interp_t mode;

  assign mode = txg_pkg::txg_interp_t'(interp_reg[7:6]);

  txg_fifo #(.W(W), .D(DEPTH)) u_fifo (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (tx_valid_i),
    .in_ready_o  (tx_ready_o),
    .in_data_i   (tx_data_i),
    .out_valid_o (f_vld),
    .out_ready_i (f_rdy),
    .out_data_o  (f_dat)
  );

  // tap lengths fix the group delay of each stage
  txg_halfband #(.W(W), .TAPS(43), .COEF({16'h4000, 160'h0})) u_hb1 (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (f_vld && mode != txg_pkg::TXG_X1),
    .in_ready_o  (s1_rdy),
    .in_data_i   (f_dat),
    .out_valid_o (s1_vld),
    .out_ready_i (s1_ordy),
    .out_data_o  (s1_dat)
  );

  txg_halfband #(.W(W), .TAPS(11), .COEF({16'h4000, 32'h0})) u_hb2 (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (s1_vld && mode == txg_pkg::TXG_X4),
    .in_ready_o  (s2_rdy),
    .in_data_i   (s1_dat),
    .out_valid_o (s2_vld),
    .out_ready_i (dac_ready_i),
    .out_data_o  (s2_dat)
  );

  always_comb
  begin
    f_rdy       = s1_rdy;
    s1_ordy     = (mode == txg_pkg::TXG_X4) ? s2_rdy : dac_ready_i;
    dac_valid_o = s2_vld;
    dac_data_o  = s2_dat;
    if (mode == txg_pkg::TXG_X1)
    begin
      f_rdy       = dac_ready_i;
      dac_valid_o = f_vld;
      dac_data_o  = f_dat;
    end
    else if (mode == txg_pkg::TXG_X2)
    begin
      dac_valid_o = s1_vld;
      dac_data_o  = s1_dat;
    end
  end

  // ----------------------------------------------------------------
  // half-duplex power-down
  // ----------------------------------------------------------------
  logic [7:0] pd_cnt_reg, pd_cnt_next;
  logic       pd_reg, pd_next, busy;

  // samples still inside the filter hold the converter up
  assign busy = f_vld | s1_vld | s2_vld;

  always_comb
  begin
    pd_cnt_next = pd_cnt_reg;
    pd_next     = pd_reg;
    if (tx_enable_i || !hd_pd_en_i || busy)
    begin
      pd_cnt_next = 8'h00;
      pd_next     = 1'b0;
    end
    else if (pd_cnt_reg == pd_delay_i)
      pd_next = 1'b1;
    else
      pd_cnt_next = pd_cnt_reg + 8'h01;
  end

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      pd_cnt_reg <= 8'h00;
      pd_reg     <= 1'b0;
    end
    else
    begin
      pd_cnt_reg <= pd_cnt_next;
      pd_reg     <= pd_next;
    end
  end

  assign tx_converter_pd_o      = pd_reg;
  assign current_amplifier_pd_o = pd_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  chk_reset_vals: assert property (@(posedge clk_i) disable iff (1'b0)
    !resetn_i |=> atten_reg == `TXG_RST_ATTEN && !sel_reg[`TXG_BIT_SEL_TX])
    else $error("attenuation or port select not cleared by reset");
  chk_port_load: assert property (sel_reg[`TXG_BIT_SEL_TX] && !wr_atten
    |=> atten_reg[5:0] == $past(gain_port_i))
    else $error("gain port not loaded into attenuation");
  chk_port_hold: assert property (!sel_reg[`TXG_BIT_SEL_TX] && !wr_atten
    |=> $stable(atten_reg[5:0]))
    else $error("attenuation changed without a source");
  chk_direct_map: assert property (route_reg[0]
    |-> tx_gain_o.conv_steps == atten_reg[3:0] && !current_amplifier_en_o)
    else $error("direct route mapping wrong");
  chk_amp_map: assert property (!route_reg[0] && atten_reg[5:0] <= `TXG_MAX_CODE
    |-> 6'(tx_gain_o.amp_steps) * `TXG_AMP_STEP + 6'(tx_gain_o.conv_steps) == atten_reg[5:0])
    else $error("amplifier gain split wrong");
  chk_interp_keep: assert property (wr && waddr == `TXG_OFS_INTERP
    && wdata[7:6] == 2'b11 |=> interp_reg[7:6] == $past(interp_reg[7:6]))
    else $error("unused interpolation code accepted");
  chk_mirror_def: assert property (!m1_reg[`TXG_BIT_MIR_EN]
    |-> mirror_o.primary == DEF_PRIM && mirror_o.sec_third == DEF_S3)
    else $error("mirror defaults not applied");
  chk_mirror_lim: assert property (m1_reg[`TXG_BIT_MIR_EN]
    |-> mirror_o.primary <= 3'h4 && mirror_o.sec_third <= 3'h5)
    else $error("mirror gain out of range");
  chk_pd_wait: assert property ($rose(pd_reg)
    |-> !$past(busy) && !$past(tx_enable_i) && $past(hd_pd_en_i))
    else $error("power-down before filter drained");
  chk_x1_pass: assert property (mode == txg_pkg::TXG_X1 && f_vld
    |-> dac_valid_o && dac_data_o == f_dat)
    else $error("bypass path broken");

  cov_pd: cover property ($rose(pd_reg));
  cov_x4: cover property (mode == txg_pkg::TXG_X4 && dac_valid_o && dac_ready_i);
  cov_spi_wr: cover property (wr_atten && wdata[`TXG_BIT_SPI_EN]);
endmodule

`default_nettype wire

// File: rtl/txg_defines.svh
/*
  Offsets, field positions, reset values and limits of the
  transmit gain and interpolation block.
  Assumes 7-bit register addresses and a 100 MHz core clock.
*/
`ifndef TXG_DEFINES_SVH
`define TXG_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TXG_OFS_ATTEN   7'h0A
`define TXG_OFS_PORTSEL 7'h0B
`define TXG_OFS_INTERP  7'h0C
`define TXG_OFS_ROUTE   7'h0E
`define TXG_OFS_MIRROR1 7'h10
`define TXG_OFS_MIRROR2 7'h11
`define TXG_OFS_OFFSET  7'h12

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TXG_BIT_SPI_EN   6
`define TXG_BIT_SEL_TX   6
`define TXG_BIT_SEL_RX   5
`define TXG_BIT_ROUTE    0
`define TXG_BIT_MIR_EN   7
`define TXG_INTERP_HI    7
`define TXG_INTERP_LO    6

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define TXG_RST_ATTEN    8'h00
`define TXG_RST_PORTSEL  8'h00
`define TXG_RST_INTERP   8'h00
`define TXG_RST_ROUTE    8'h00
`define TXG_RST_MIRROR1  8'h44
`define TXG_RST_MIRROR2  8'h00
`define TXG_RST_OFFSET   8'h00
`define TXG_MAX_CODE     6'h27
`define TXG_AMP_STEP     6'h0C
`define TXG_SPI_BITS     5'h10

`endif

// File: rtl/txg_pkg.sv
/*
  Types shared by the transmit gain and interpolation block.
  Assumes nothing of its surroundings.
*/
package txg_pkg;

  typedef enum logic [1:0] {
    TXG_X4 = 2'b00,
    TXG_X2 = 2'b01,
    TXG_X1 = 2'b10,
    TXG_XX = 2'b11
  } txg_interp_t;

  typedef struct packed {
    logic [3:0] conv_steps;
    logic [1:0] amp_steps;
  } txg_gain_t;

  typedef struct packed {
    logic [2:0] primary;
    logic [2:0] sec_first;
    logic [2:0] sec_second;
    logic [2:0] sec_third;
  } txg_mirror_t;

  typedef struct packed {
    logic [2:0] secondary;
    logic [2:0] primary;
  } txg_offset_t;

endpackage

// File: test/tb.sv
/*
  Self-checking bench for the transmit gain and interpolation block.
  Assumes the host model beside it and default block parameters.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic clk_i = 1'h0, resetn_i = 1'h0, spi_sclk_i = 1'h0, spi_csn_i = 1'h1, spi_sdi_i = 1'h0;
  logic dac_ready_i = 1'h1, tx_enable_i = 1'h1, hd_pd_en_i = 1'h0, go = 1'h0;
  logic [5:0] gain_port_i = 6'h3F, num = 6'h00, sent, rx_gain_stage_o;
  logic [7:0] pd_delay_i = 8'h04;
  logic [11:0] tx_data_i, dac_data_o;
  logic spi_sdo_o, spi_sdo_oe_o, rx_gain_stage_load_o, tx_valid_i, tx_ready_o, dac_valid_o;
  logic converter_direct_o, current_amplifier_en_o, tx_converter_pd_o, current_amplifier_pd_o;
  txg_pkg::txg_gain_t   tx_gain_o;
  txg_pkg::txg_mirror_t mirror_o;
  txg_pkg::txg_offset_t offset_current_o;
  int fails = 0, n_checks = 0;

  always #5 clk_i = ~clk_i;

  txg_core u_txg_core (
    .clk_i, .resetn_i, .spi_sclk_i, .spi_csn_i, .spi_sdi_i, .spi_sdo_o, .spi_sdo_oe_o,
    .gain_port_i, .rx_gain_stage_o, .rx_gain_stage_load_o, .tx_valid_i, .tx_ready_o,
    .tx_data_i, .tx_enable_i, .dac_valid_o, .dac_ready_i, .dac_data_o, .tx_gain_o,
    .converter_direct_o, .current_amplifier_en_o, .mirror_o, .offset_current_o,
    .hd_pd_en_i, .pd_delay_i, .tx_converter_pd_o, .current_amplifier_pd_o
  );
  txg_host_model u_txg_host_model (
    .clk_i, .resetn_i, .num_i(num), .go_i(go), .valid_o(tx_valid_i),
    .ready_i(tx_ready_o), .data_o(tx_data_i), .sent_o(sent)
  );

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic lim(input logic ok);
    if (!ok)
    begin
      fails++;
      end_sim();
    end
  endtask

  // sclk phases are kept well above the two-cycle minimum of the sampler
  task automatic spi(input logic [15:0] f, output logic [7:0] q);
    q = 8'h00;
    spi_csn_i <= 1'h0;
    for (int i = 15; i >= 0; i--)
    begin
      spi_sdi_i <= f[i];
      cyc(4);
      if (i < 8)
        q[i] = spi_sdo_o;
      if (i == 0)
        chk(spi_sdo_oe_o, f[15]);
      spi_sclk_i <= 1'h1;
      cyc(3);
      spi_sclk_i <= 1'h0;
    end
    cyc(4);
    spi_csn_i <= 1'h1;
    cyc(4);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    spi({1'h0, a, d}, q);
  endtask

  task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] q;
    spi({1'h1, a, 8'h00}, q);
    chk(q, exp);
    chk(spi_sdo_oe_o, 1'h0);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [6:0] a [8] = '{7'h0A, 7'h0B, 7'h0C, 7'h0E, 7'h10, 7'h11, 7'h12, 7'h0D};
    logic [7:0] v [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h44, 8'h00, 8'h00, 8'h00};
    wr(7'h0D, 8'h5A);
    for (int i = 0; i < 8; i++)
      rdc(a[i], v[i]);
    chk(tx_gain_o, 6'h00);
    chk(mirror_o, {3'h4, 3'h4, 3'h4, 3'h3});
    $display("test reset done");
  endtask

  task automatic t_atten;
    wr(7'h0A, 8'h5B);
    rdc(7'h0A, 8'h5B);
    chk(tx_gain_o, {4'h3, 2'h2});
    wr(7'h0E, 8'h01);
    chk({converter_direct_o, current_amplifier_en_o, tx_gain_o}, {2'h2, 4'hB, 2'h0});
    wr(7'h0E, 8'h00);
    chk({converter_direct_o, current_amplifier_en_o}, 2'h1);
    wr(7'h0A, 8'h3F);
    rdc(7'h0A, 8'h1B);
    wr(7'h0A, 8'h7F);
    chk(tx_gain_o, {4'hF, 2'h2});
    $display("test attenuation done");
  endtask

  task automatic t_port;
    gain_port_i <= 6'h15;
    wr(7'h0B, 8'h20);
    chk({rx_gain_stage_load_o, rx_gain_stage_o, tx_gain_o}, {1'h1, 6'h15, 4'hF, 2'h2});
    wr(7'h0B, 8'h00);
    gain_port_i <= 6'h2A;
    wr(7'h0B, 8'h40);
    rdc(7'h0A, 8'h6A);
    gain_port_i <= 6'h07;
    cyc(2);
    chk({rx_gain_stage_load_o, tx_gain_o}, {1'h0, 4'h7, 2'h0});
    wr(7'h0B, 8'h00);
    gain_port_i <= 6'h01;
    cyc(2);
    chk(tx_gain_o, {4'h7, 2'h0});
    $display("test gain port done");
  endtask

  task automatic t_cfg;
    for (int m = 0; m < 3; m++)
    begin
      wr(7'h0C, {m[1:0], 6'h00});
      rdc(7'h0C, {m[1:0], 6'h00});
    end
    wr(7'h0C, 8'hC0);
    rdc(7'h0C, 8'h80);
    wr(7'h10, 8'h84);
    chk(mirror_o, {3'h4, 3'h0, 3'h0, 3'h0});
    wr(7'h11, 8'h65);
    chk(mirror_o, {3'h4, 3'h0, 3'h6, 3'h5});
    wr(7'h10, 8'hF7);
    chk(mirror_o, {3'h4, 3'h4, 3'h6, 3'h5});
    wr(7'h10, 8'h44);
    chk(mirror_o, {3'h4, 3'h4, 3'h4, 3'h3});
    wr(7'h12, 8'h53);
    chk(offset_current_o, {3'h5, 3'h3});
    $display("test config done");
  endtask

  // factor 1 is left set; the far side stalls until the buffer refuses
  task automatic t_fifo;
    int k;
    int n = 0;
    dac_ready_i <= 1'h0;
    num <= 6'h28;
    go <= 1'h1;
    cyc(1);
    go <= 1'h0;
    cyc(150);
    chk({tx_ready_o, sent}, {1'h0, 6'h20});
    dac_ready_i <= 1'h1;
    for (k = 0; k < 300 && n < 40; k++)
    begin
      @(negedge clk_i);
      if (dac_valid_o === 1'h1)
      begin
        chk(dac_data_o, {6'h0A, n[5:0]});
        n++;
      end
    end
    lim(n == 40);
    cyc(1);
    $display("test buffer done");
  endtask

  task automatic t_rate(input logic [7:0] mode, input int exp);
    int n = 0;
    wr(7'h0C, mode);
    num <= 6'h04;
    go <= 1'h1;
    cyc(1);
    go <= 1'h0;
    repeat (400)
    begin
      @(negedge clk_i);
      if (dac_valid_o === 1'h1)
        n++;
    end
    cyc(1);
    chk(n, exp);
    $display("test interpolation done");
  endtask

  task automatic t_pd;
    int k;
    hd_pd_en_i <= 1'h1;
    tx_enable_i <= 1'h0;
    for (k = 0; k < 100 && tx_converter_pd_o !== 1'h1; k++)
      cyc(1);
    lim(k < 100);
    chk(k, 32'h6);
    chk({current_amplifier_pd_o, current_amplifier_en_o}, 2'h2);
    tx_enable_i <= 1'h1;
    cyc(2);
    chk(tx_converter_pd_o, 1'h0);
    $display("test power-down done");
  endtask

  initial
  begin
    cyc(20);
    resetn_i <= 1'h1;
    cyc(2);
    t_reset();
    t_atten();
    t_port();
    t_cfg();
    t_fifo();
    t_rate(8'h40, 8);
    t_rate(8'h00, 16);
    t_pd();
    end_sim();
  end
endmodule
`default_nettype wire

// File: test/txg_host_model.sv
/*
  Host model: streams a numbered run of transmit samples into the block.
  Assumes the block's valid/ready sample handshake on clk_i.
*/
`timescale 1ns/10ps
`default_nettype none

module txg_host_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // run control
  input  wire logic [5:0]  num_i,
  input  wire logic        go_i,
  // sample port
  output logic             valid_o,
  input  wire logic        ready_i,
  output logic [11:0]      data_o,
  output logic [5:0]       sent_o
);
  // idle word is inverted so a stale value never passes for a live one
  assign data_o = valid_o ? {6'h0A, sent_o} : ~{6'h0A, sent_o};

  always_ff @(posedge clk_i)
  begin
    if (!resetn_i || go_i)
    begin
      valid_o <= 1'h0;
      sent_o  <= 6'h00;
    end
    else if (valid_o && ready_i)
    begin
      valid_o <= 1'h0;
      sent_o  <= sent_o + 6'h01;
    end
    else if (sent_o < num_i)
      valid_o <= 1'h1;
  end
endmodule
`default_nettype wire
